// File: bench/interval_timers_slow_control_checker.sv
// timing checks on the timer register link
`timescale 1ns/1ps
module interval_timers_slow_control_checker
    import timers_pkg::*;
(
    // clock and reset
    input logic        pclk,
    input logic        presetn,
    // link
    input logic [15:0] host_addr,
    input logic        host_write_read_n,
    input logic [2:0]  cycle_status,
    input logic        cmd_n,
    input logic [7:0]  host_wdata,
    input logic [7:0]  dev_rdata,
    input logic        slave_data_ready,
    input logic        chip_select_out_n
);
    logic hole;
    logic fast;
    assign hole = host_addr == 16'h0049;
    assign fast = cycle_status[ST_ISA_BIT]
        && (hole || host_addr == ADDR_SYS_PORT || host_addr == ADDR_NMI_PORT);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_fast_wait: assert property ($fell(cmd_n) && fast |->
        !slave_data_ready[*4] ##[1:2] slave_data_ready) else $error("fast wait wrong");
    a_slow_wait: assert property ($fell(cmd_n) && !fast |->
        !slave_data_ready[*7] ##[1:2] slave_data_ready) else $error("slow wait wrong");
    a_ready_hold: assert property (slave_data_ready && !cmd_n |=> slave_data_ready)
        else $error("ready dropped early");
    a_ready_drop: assert property (slave_data_ready && cmd_n |-> ##[1:2] !slave_data_ready)
        else $error("ready stuck");
    a_hole_reads_ff: assert property (slave_data_ready && hole && !host_write_read_n |->
        dev_rdata == 8'hFF) else $error("unmapped read not FF");
    a_hole_no_cs: assert property (hole && !cmd_n |-> chip_select_out_n)
        else $error("unmapped select");
    a_mapped_cs: assert property ($fell(cmd_n) && !hole |-> ##[1:2] !chip_select_out_n)
        else $error("no select");
    a_idle_no_cs: assert property (cmd_n[*3] |-> chip_select_out_n)
        else $error("select while idle");
endmodule : interval_timers_slow_control_checker

// File: bench/interval_timers_slow_control_tb.sv
// self-checking bench: host bridge driving the interval timers
`timescale 1ns/1ps
module interval_timers_slow_control_tb
    import timers_pkg::*;
;
    logic        pclk = 0;
    logic        presetn = 0;
    logic        ref_osc_in = 0;
    logic        psel = 0;
    logic        penable = 0;
    logic        pwrite = 0;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq0;
    logic        speaker_out;
    logic        refresh_req;
    logic        fail_safe_nmi;
    logic        cpu_slow_out_n;
    logic [31:0] r;
    logic        e;
    logic [7:0]  q;
    logic [7:0]  d;
    logic        h;
    int          errors = 0;
    int          n_compared = 0;
    int          n;
    int          w;
    int          falls;

    initial begin
        forever #4 pclk = ~pclk;
    end
    initial begin
        forever #34.92 ref_osc_in = ~ref_osc_in;
    end

    timer_link_if lk ();
    interval_timers #(.DIV_SYS(2), .DIV_FS(4)) i_interval_timers (
        .pclk(pclk), .presetn(presetn), .ref_osc_in(ref_osc_in), .link(lk), .irq0(irq0),
        .refresh_req(refresh_req), .speaker_out(speaker_out), .fail_safe_nmi(fail_safe_nmi),
        .cpu_slow_out_n(cpu_slow_out_n));
    timer_host_bridge i_timer_host_bridge (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(lk));
    interval_timers_slow_control_checker i_chk (
        .pclk(pclk), .presetn(presetn), .host_addr(lk.host_addr),
        .host_write_read_n(lk.host_write_read_n), .cycle_status(lk.cycle_status),
        .cmd_n(lk.cmd_n), .host_wdata(lk.host_wdata), .dev_rdata(lk.dev_rdata),
        .slave_data_ready(lk.slave_data_ready), .chip_select_out_n(lk.chip_select_out_n));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dt);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= dt;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // one i/o cycle on the link, polled to completion
    task automatic io(input logic wr, input logic isa, input logic [15:0] a,
                      input logic [7:0] dt);
        apb(1'b1, HOST_CMD_OFS, {6'h00, isa, wr, a, dt});
        do apb(1'b0, HOST_STAT_OFS, 32'h0); while (r[STAT_BUSY_BIT] !== 1'b0);
        q = r[15:8];
        h = r[STAT_HIT_BIT];
    endtask : io

    task automatic test_done;
        $display("errors=%0d compared=%0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : test_done

    initial begin
        #200000;
        errors++;
        test_done;
    end

    initial begin
        n = $urandom(32'hA0E8);
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h08, 32'h0);
        chk(e, 1'b1);
        io(1'b0, 1'b1, ADDR_NMI_PORT, 8'h00);
        chk(q & 8'h84, 8'h04);
        io(1'b0, 1'b1, 16'h0049, 8'h00);
        chk({h, q}, 9'h0FF);
        // speaker counter in mode 2 holds its output high while unloaded
        io(1'b1, 1'b0, ADDR_G1_CTRL, 8'h94);
        repeat (4) begin
            d = 8'($urandom);
            io(1'b1, d[7], ADDR_SYS_PORT, d & 8'h03);
            io(1'b0, d[6], ADDR_SYS_PORT, 8'h00);
            chk({speaker_out, q[SYS_SPK_OUT_BIT], q[1:0]}, {d[1], 1'b1, d[1:0]});
        end
        // system tick: mode 0, count 3 written low byte then high byte
        io(1'b1, 1'b0, ADDR_G1_CTRL, 8'h30);
        io(1'b1, 1'b0, ADDR_G1_CNT0, 8'h03);
        io(1'b1, 1'b1, ADDR_G1_CNT0, 8'h00);
        chk(irq0, 1'b0);
        io(1'b1, 1'b0, ADDR_G1_CTRL, 8'h54);
        io(1'b1, 1'b0, ADDR_G1_CNT1, 8'h04);
        io(1'b1, 1'b0, ADDR_G2_CTRL, 8'h14);
        io(1'b1, 1'b0, ADDR_G2_CNT0, 8'h02);
        io(1'b1, 1'b1, ADDR_NMI_PORT, 8'h00);
        w = 0;
        repeat (300) begin
            @(posedge pclk);
            if (cpu_slow_out_n !== 1'b1) w++;
        end
        chk(w, 0);
        chk(irq0, 1'b1);
        io(1'b0, 1'b1, ADDR_NMI_PORT, 8'h00);
        chk({fail_safe_nmi, q[7]}, 2'b11);
        io(1'b1, 1'b1, ADDR_NMI_PORT, 8'h04);
        io(1'b0, 1'b0, ADDR_NMI_PORT, 8'h00);
        chk({fail_safe_nmi, q[7]}, 2'b00);
        n = 10 + $urandom % 30;
        io(1'b1, 1'b0, ADDR_G2_CTRL, SLOW_ONESHOT_CW);
        io(1'b1, 1'b0, ADDR_G2_CNT2, 8'(n));
        @(negedge cpu_slow_out_n);
        w = 0;
        forever begin
            @(posedge pclk);
            if (cpu_slow_out_n !== 1'b0) break;
            w++;
        end
        chk(w, n);
        @(posedge refresh_req);
        falls = 0;
        fork
            repeat (4) @(posedge refresh_req);
            forever @(negedge cpu_slow_out_n) falls++;
        join_any
        disable fork;
        chk(falls, 4);
        test_done;
    end
endmodule : interval_timers_slow_control_tb

// File: rtl/interval_timers.sv
// five interval counters, slow-down one-shot and fail-safe latch
// Summary of operation
// - five counters: group one three, group two
// - group two counter 1 absent
// - bus clock or oscillator /12, /48
// - g1 counter0: osc/12, gate on, drives irq0
// - g1 counter1: osc/12, gate on, refresh request
// - g1 counter2: speaker tone, gate port 61h
// - g2 counter0: osc/48, gate on, fail-safe
// - g2 counter2: bus clock, refresh-gated, slow pin
// - slow pin idle until counter programmed
// - one-shot slow pulse every refresh request
// - software writes 92h to 4Bh
// - refresh cycles decoupled from slow pulse
// - refresh rate sets slow-down repetition
// - leave slow counter unloaded until needed
// - 8-bit slave with 8-bit data
// - non-isa 6 clocks; isa 3 or 6
// - slow isa access extended by data ready
// - fail-safe rising edge latched for nmi
// - fail-safe status bit7, control bit2, 461h
`timescale 1ns/1ps
module interval_timers
    import timers_pkg::*;
#(
    parameter int DIV_SYS = OSC_DIV_SYS,
    parameter int DIV_FS  = OSC_DIV_FS
) (
    // clock and reset
    input  logic         pclk,
    input  logic         presetn,
    // oscillator pin
    input  logic         ref_osc_in,
    // register link
    timer_link_if.device link,
    // timer outputs
    output logic         irq0,
    output logic         refresh_req,
    output logic         speaker_out,
    output logic         fail_safe_nmi,
    output logic         cpu_slow_out_n
);

    localparam int FS_RATIO = DIV_FS / DIV_SYS;

    if (DIV_SYS < 2 || DIV_SYS > 16 || FS_RATIO < 1 || FS_RATIO > 4 ||
        DIV_FS % DIV_SYS != 0) begin : g_bad_div
        $error("interval_timers: unsupported divider setting");
    end

    localparam logic [4:0][15:0] CTR_ADDR = {ADDR_G2_CNT2, ADDR_G2_CNT0, ADDR_G1_CNT2,
                                             ADDR_G1_CNT1, ADDR_G1_CNT0};
    localparam logic [4:0][15:0] CTR_CTRL = {ADDR_G2_CTRL, ADDR_G2_CTRL, ADDR_G1_CTRL,
                                             ADDR_G1_CTRL, ADDR_G1_CTRL};
    localparam logic [4:0][1:0]  CTR_SEL  = {2'h2, 2'h0, 2'h2, 2'h1, 2'h0};
    localparam logic [3:0] DIV_SYS_LAST = 4'(DIV_SYS - 1);
    localparam logic [1:0] FS_LAST      = 2'(FS_RATIO - 1);

    typedef struct packed {
        counter_t [NUM_CTR-1:0] ctr;
        logic [2:0]  osc_sync;
        logic [3:0]  div_sys;
        logic [1:0]  div_fs;
        logic [1:0]  sys_ctl;
        logic        fs_ctl;
        logic        fs_stat;
        logic        busy;
        logic [2:0]  wait_cnt;
        logic        rdy;
        logic [7:0]  rdata;
        logic        cs_n;
        logic        irq0;
        logic        refresh;
        logic        speaker;
        logic        nmi;
        logic        slow_n;
    } dev_state_t;

    dev_state_t s;
    dev_state_t next_s;

    always_comb begin
        logic            osc_edge;
        logic            tick_sys;
        logic            tick_fs;
        logic            hit;
        logic            slow_reg;
        logic            acc;
        logic            wr;
        logic            gate;
        logic            tick;
        logic            one_shot;
        logic            done;
        logic            fs_edge;
        logic [2:0]      m;
        logic [15:0]     v;
        logic [7:0]      rd;
        logic [7:0]      d;
        osc_edge = 1'b0;
        tick_sys = 1'b0;
        tick_fs  = 1'b0;
        hit      = 1'b0;
        slow_reg = 1'b0;
        acc      = 1'b0;
        wr       = 1'b0;
        gate     = 1'b0;
        tick     = 1'b0;
        one_shot = 1'b0;
        done     = 1'b0;
        fs_edge  = 1'b0;
        m        = 3'h0;
        v        = 16'h0000;
        rd       = 8'hFF;
        d        = link.host_wdata;
        next_s   = s;

        // oscillator edge found on the synchronised copy only
        next_s.osc_sync = {s.osc_sync[1:0], ref_osc_in};
        osc_edge = s.osc_sync[1] & ~s.osc_sync[2];
        if (osc_edge) begin
            if (s.div_sys == DIV_SYS_LAST) begin
                next_s.div_sys = 4'h0;
                tick_sys = 1'b1;
                next_s.div_fs = (s.div_fs == FS_LAST) ? 2'h0 : s.div_fs + 2'h1;
                tick_fs = (s.div_fs == FS_LAST);
            end else begin
                next_s.div_sys = s.div_sys + 4'h1;
            end
        end

        // counting
        for (int i = 0; i < NUM_CTR; i++) begin
            unique case (i)
                2:       gate = s.sys_ctl[SYS_SPK_GATE_BIT];
                4:       gate = s.ctr[1].out;
                default: gate = 1'b1;
            endcase
            unique case (i)
                3:       tick = tick_fs;
                4:       tick = 1'b1;
                default: tick = tick_sys;
            endcase
            one_shot = (s.ctr[i].mode == MODE_ONESHOT) || (s.ctr[i].mode == MODE_HWSTB);
            if (tick && s.ctr[i].programmed) begin
                next_s.ctr[i].gate_prev = gate;
                if (s.ctr[i].load_pend && !one_shot) begin
                    next_s.ctr[i].cnt = s.ctr[i].reload;
                    next_s.ctr[i].load_pend = 1'b0;
                end else if (one_shot && gate && !s.ctr[i].gate_prev) begin
                    next_s.ctr[i].cnt = s.ctr[i].reload;
                    next_s.ctr[i].load_pend = 1'b0;
                    if (s.ctr[i].mode == MODE_ONESHOT) begin
                        next_s.ctr[i].out = 1'b0;
                    end
                end else if (!s.ctr[i].load_pend && (gate || one_shot)) begin
                    next_s.ctr[i].cnt = s.ctr[i].cnt - 16'h0001;
                    unique case (s.ctr[i].mode)
                        MODE_INT, MODE_ONESHOT: begin
                            if (s.ctr[i].cnt == 16'h0001) begin
                                next_s.ctr[i].out = 1'b1;
                            end
                        end
                        MODE_RATE: begin
                            next_s.ctr[i].out = (s.ctr[i].cnt != 16'h0002);
                            if (s.ctr[i].cnt == 16'h0001) begin
                                next_s.ctr[i].cnt = s.ctr[i].reload;
                            end
                        end
                        MODE_SQUARE: begin
                            next_s.ctr[i].cnt = s.ctr[i].cnt - 16'h0002;
                            if (s.ctr[i].cnt <= 16'h0002) begin
                                next_s.ctr[i].out = ~s.ctr[i].out;
                                next_s.ctr[i].cnt = s.ctr[i].reload;
                            end
                        end
                        default: begin
                            next_s.ctr[i].out = (s.ctr[i].cnt != 16'h0001);
                        end
                    endcase
                end else if (!gate && (s.ctr[i].mode == MODE_RATE ||
                                       s.ctr[i].mode == MODE_SQUARE)) begin
                    next_s.ctr[i].out = 1'b1;
                end
            end
        end

        // register link, one access per strobe
        wr  = link.host_write_read_n;
        acc = s.busy && (s.wait_cnt == 3'h1);
        for (int i = 0; i < NUM_CTR; i++) begin
            if (link.host_addr == CTR_ADDR[i]) begin
                hit = 1'b1;
                slow_reg = 1'b1;
            end
            if (link.host_addr == CTR_CTRL[i]) begin
                hit = 1'b1;
                slow_reg = 1'b1;
            end
        end
        if (link.host_addr == ADDR_SYS_PORT || link.host_addr == ADDR_NMI_PORT) begin
            hit = 1'b1;
        end
        if (link.cmd_n) begin
            next_s.busy = 1'b0;
            next_s.rdy  = 1'b0;
            next_s.cs_n = 1'b1;
            next_s.wait_cnt = 3'h0;
        end else if (!s.busy && !s.rdy && link.cycle_status[ST_IO_BIT]) begin
            next_s.busy = 1'b1;
            next_s.cs_n = ~hit;
            next_s.wait_cnt = (link.cycle_status[ST_ISA_BIT] && !slow_reg) ?
                              WAIT_FAST : WAIT_SLOW;
        end else if (s.busy) begin
            next_s.wait_cnt = s.wait_cnt - 3'h1;
            if (acc) begin
                next_s.busy = 1'b0;
                next_s.rdy  = 1'b1;
            end
        end

        if (acc) begin
            for (int i = 0; i < NUM_CTR; i++) begin
                if (link.host_addr == CTR_ADDR[i]) begin
                    if (wr) begin
                        done = 1'b0;
                        unique case (s.ctr[i].rw)
                            RW_LSB: begin
                                next_s.ctr[i].reload = {8'h00, d};
                                done = 1'b1;
                            end
                            RW_MSB: begin
                                next_s.ctr[i].reload = {d, 8'h00};
                                done = 1'b1;
                            end
                            RW_BOTH: begin
                                next_s.ctr[i].wr_hi = ~s.ctr[i].wr_hi;
                                next_s.ctr[i].lsb_hold = d;
                                next_s.ctr[i].reload = {d, s.ctr[i].lsb_hold};
                                done = s.ctr[i].wr_hi;
                            end
                            default: done = 1'b0;
                        endcase
                        if (done && s.ctr[i].rw != RW_LATCH) begin
                            next_s.ctr[i].programmed = 1'b1;
                            next_s.ctr[i].load_pend = 1'b1;
                            if (s.ctr[i].mode == MODE_INT) begin
                                next_s.ctr[i].out = 1'b0;
                            end
                        end
                    end else begin
                        v = s.ctr[i].latched ? s.ctr[i].latch : s.ctr[i].cnt;
                        unique case (s.ctr[i].rw)
                            RW_MSB:  rd = v[15:8];
                            RW_BOTH: rd = s.ctr[i].rd_hi ? v[15:8] : v[7:0];
                            default: rd = v[7:0];
                        endcase
                        if (s.ctr[i].rw == RW_BOTH) begin
                            next_s.ctr[i].rd_hi = ~s.ctr[i].rd_hi;
                        end
                        if (s.ctr[i].rw != RW_BOTH || s.ctr[i].rd_hi) begin
                            next_s.ctr[i].latched = 1'b0;
                        end
                    end
                end
                // a select of 01 in group two reaches no counter
                if (link.host_addr == CTR_CTRL[i] && wr &&
                    d[CW_SEL_LSB +: 2] == CTR_SEL[i]) begin
                    if (d[CW_RW_LSB +: 2] == RW_LATCH) begin
                        if (!s.ctr[i].latched) begin
                            next_s.ctr[i].latched = 1'b1;
                            next_s.ctr[i].latch = s.ctr[i].cnt;
                        end
                    end else begin
                        m = d[CW_MODE_LSB +: 3];
                        if (m[1]) begin
                            m[2] = 1'b0;
                        end
                        next_s.ctr[i].rw = d[CW_RW_LSB +: 2];
                        next_s.ctr[i].mode = m;
                        next_s.ctr[i].programmed = 1'b0;
                        next_s.ctr[i].load_pend = 1'b0;
                        next_s.ctr[i].wr_hi = 1'b0;
                        next_s.ctr[i].rd_hi = 1'b0;
                        next_s.ctr[i].latched = 1'b0;
                        next_s.ctr[i].gate_prev = 1'b1;
                        next_s.ctr[i].out = (m != MODE_INT);
                    end
                end
            end
            if (link.host_addr == ADDR_SYS_PORT) begin
                if (wr) begin
                    next_s.sys_ctl = d[1:0];
                end
                rd = 8'h00;
                rd[1:0] = s.sys_ctl;
                rd[SYS_SPK_OUT_BIT] = s.ctr[2].out;
            end
            if (link.host_addr == ADDR_NMI_PORT) begin
                if (wr) begin
                    next_s.fs_ctl = d[NMI_FS_CTRL_BIT];
                end
                rd = 8'h00;
                rd[NMI_FS_CTRL_BIT] = s.fs_ctl;
                rd[NMI_FS_STAT_BIT] = s.fs_stat;
            end
            next_s.rdata = rd;
        end

        // fail-safe edge latch, the edge beats a clear in the same cycle
        fs_edge = next_s.ctr[3].out & ~s.ctr[3].out;
        if (fs_edge && !s.fs_ctl) begin
            next_s.fs_stat = 1'b1;
        end else if (next_s.fs_ctl) begin
            next_s.fs_stat = 1'b0;
        end

        // output copies; refresh timing on the bus is left to the arbiter
        next_s.irq0    = next_s.ctr[0].out;
        next_s.refresh = next_s.ctr[1].out;
        next_s.speaker = next_s.ctr[2].out & next_s.sys_ctl[SYS_SPK_DATA_BIT];
        next_s.nmi     = next_s.fs_stat;
        next_s.slow_n  = next_s.ctr[4].programmed ? next_s.ctr[4].out : 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s         <= '0;
            s.sys_ctl <= SYS_PORT_RST;
            s.fs_ctl  <= FS_CTRL_RST;
            s.cs_n    <= 1'b1;
            s.slow_n  <= 1'b1;
            s.rdata   <= 8'hFF;
        end else begin
            s <= next_s;
        end
    end

    assign link.dev_rdata         = s.rdata;
    assign link.slave_data_ready  = s.rdy;
    assign link.chip_select_out_n = s.cs_n;
    assign irq0                   = s.irq0;
    assign refresh_req            = s.refresh;
    assign speaker_out            = s.speaker;
    assign fail_safe_nmi          = s.nmi;
    assign cpu_slow_out_n         = s.slow_n;

endmodule : interval_timers

// File: rtl/timer_host_bridge.sv
// apb-driven master that runs 8-bit i/o cycles on the timer link
`timescale 1ns/1ps
module timer_host_bridge
    import timers_pkg::*;
(
    // clock and reset
    input  logic         pclk,
    input  logic         presetn,
    // apb slave
    input  logic         psel,
    input  logic         penable,
    input  logic         pwrite,
    input  logic [7:0]   paddr,
    input  logic [31:0]  pwdata,
    output logic [31:0]  prdata,
    output logic         pready,
    output logic         pslverr,
    // register link
    timer_link_if.host   link
);

    typedef struct packed {
        host_state_t fsm;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        write;
        logic        isa;
        logic        cmd_n;
        logic [7:0]  rdata;
        logic        hit;
    } host_reg_t;

    host_reg_t s;
    host_reg_t next_s;

    always_comb begin
        next_s         = s;
        next_s.pready  = 1'b0;
        next_s.pslverr = 1'b0;

        if (psel && penable && !s.pready) begin
            next_s.pready = 1'b1;
            next_s.prdata = 32'h0000_0000;
            if (paddr == HOST_STAT_OFS) begin
                if (!pwrite) begin
                    next_s.prdata[STAT_BUSY_BIT] = (s.fsm != H_IDLE);
                    next_s.prdata[STAT_RDATA_LSB +: 8] = s.rdata;
                    next_s.prdata[STAT_HIT_BIT] = s.hit;
                end
            end else if (paddr == HOST_CMD_OFS) begin
                // a launch while a cycle runs is dropped
                if (pwrite && s.fsm == H_IDLE) begin
                    next_s.wdata = pwdata[CMD_WDATA_LSB +: 8];
                    next_s.addr  = pwdata[CMD_ADDR_LSB +: 16];
                    next_s.write = pwdata[CMD_WRITE_BIT];
                    next_s.isa   = pwdata[CMD_ISA_BIT];
                    next_s.cmd_n = 1'b0;
                    next_s.fsm   = H_STROBE;
                end
            end else begin
                next_s.pslverr = 1'b1;
            end
        end

        unique case (s.fsm)
            H_IDLE: begin
            end
            H_STROBE: begin
                // strobe held until the device says data ready
                if (link.slave_data_ready) begin
                    next_s.rdata = link.dev_rdata;
                    next_s.hit   = ~link.chip_select_out_n;
                    next_s.cmd_n = 1'b1;
                    next_s.fsm   = H_RELEASE;
                end
            end
            H_RELEASE: begin
                if (!link.slave_data_ready) begin
                    next_s.fsm = H_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s       <= '0;
            s.fsm   <= H_IDLE;
            s.cmd_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign prdata                 = s.prdata;
    assign pready                 = s.pready;
    assign pslverr                = s.pslverr;
    assign link.host_addr         = s.addr;
    assign link.host_wdata        = s.wdata;
    assign link.host_write_read_n = s.write;
    assign link.cmd_n             = s.cmd_n;
    assign link.cycle_status      = {s.isa, 1'b0, ~s.cmd_n};

endmodule : timer_host_bridge

// File: rtl/timer_link_if.sv
// register access link between host bridge and timer device
`timescale 1ns/1ps
interface timer_link_if;
    logic [15:0] host_addr;
    logic        host_write_read_n;
    logic [2:0]  cycle_status;
    logic        cmd_n;
    logic [7:0]  host_wdata;
    logic [7:0]  dev_rdata;
    logic        slave_data_ready;
    logic        chip_select_out_n;

    modport device (
        input  host_addr, host_write_read_n, cycle_status, cmd_n, host_wdata,
        output dev_rdata, slave_data_ready, chip_select_out_n
    );
    modport host (
        output host_addr, host_write_read_n, cycle_status, cmd_n, host_wdata,
        input  dev_rdata, slave_data_ready, chip_select_out_n
    );
endinterface : timer_link_if

// File: rtl/timers_pkg.sv
// shared constants and types for the interval timer block and its host bridge
package timers_pkg;

    // device i/o map
    localparam logic [15:0] ADDR_G1_CNT0 = 16'h0040;
    localparam logic [15:0] ADDR_G1_CNT1 = 16'h0041;
    localparam logic [15:0] ADDR_G1_CNT2 = 16'h0042;
    localparam logic [15:0] ADDR_G1_CTRL = 16'h0043;
    localparam logic [15:0] ADDR_G2_CNT0 = 16'h0048;
    localparam logic [15:0] ADDR_G2_CNT2 = 16'h004A;
    localparam logic [15:0] ADDR_G2_CTRL = 16'h004B;
    localparam logic [15:0] ADDR_SYS_PORT = 16'h0061;
    localparam logic [15:0] ADDR_NMI_PORT = 16'h0461;

    // control value that arms the slow-down one-shot
    localparam logic [7:0] SLOW_ONESHOT_CW = 8'h92;

    // control word fields
    localparam int CW_SEL_LSB  = 6;
    localparam int CW_RW_LSB   = 4;
    localparam int CW_MODE_LSB = 1;

    // counter modes
    localparam logic [2:0] MODE_INT     = 3'h0;
    localparam logic [2:0] MODE_ONESHOT = 3'h1;
    localparam logic [2:0] MODE_RATE    = 3'h2;
    localparam logic [2:0] MODE_SQUARE  = 3'h3;
    localparam logic [2:0] MODE_SWSTB   = 3'h4;
    localparam logic [2:0] MODE_HWSTB   = 3'h5;

    // access kinds
    localparam logic [1:0] RW_LATCH = 2'h0;
    localparam logic [1:0] RW_LSB   = 2'h1;
    localparam logic [1:0] RW_MSB   = 2'h2;
    localparam logic [1:0] RW_BOTH  = 2'h3;

    // port bits
    localparam int SYS_SPK_GATE_BIT = 0;
    localparam int SYS_SPK_DATA_BIT = 1;
    localparam int SYS_SPK_OUT_BIT  = 5;
    localparam int NMI_FS_CTRL_BIT  = 2;
    localparam int NMI_FS_STAT_BIT  = 7;
    localparam logic [1:0] SYS_PORT_RST = 2'h0;
    localparam logic FS_CTRL_RST = 1'b1;

    // cycle status bits
    localparam int ST_IO_BIT  = 0;
    localparam int ST_ISA_BIT = 2;

    // clocking and access timing
    localparam int NUM_CTR     = 5;
    localparam int OSC_DIV_SYS = 12;
    localparam int OSC_DIV_FS  = 48;
    localparam logic [2:0] WAIT_FAST = 3'h3;
    localparam logic [2:0] WAIT_SLOW = 3'h6;

    // host bridge apb map
    localparam logic [7:0] HOST_CMD_OFS  = 8'h00;
    localparam logic [7:0] HOST_STAT_OFS = 8'h04;
    localparam int CMD_WDATA_LSB  = 0;
    localparam int CMD_ADDR_LSB   = 8;
    localparam int CMD_WRITE_BIT  = 24;
    localparam int CMD_ISA_BIT    = 25;
    localparam int STAT_BUSY_BIT  = 0;
    localparam int STAT_RDATA_LSB = 8;
    localparam int STAT_HIT_BIT   = 16;

    typedef struct packed {
        logic [15:0] cnt;
        logic [15:0] reload;
        logic [15:0] latch;
        logic [7:0]  lsb_hold;
        logic [2:0]  mode;
        logic [1:0]  rw;
        logic        programmed;
        logic        load_pend;
        logic        wr_hi;
        logic        rd_hi;
        logic        latched;
        logic        out;
        logic        gate_prev;
    } counter_t;

    typedef enum logic [1:0] {H_IDLE, H_STROBE, H_RELEASE} host_state_t;

endpackage : timers_pkg
